// ==== rtl/boundary_scan_pkg.sv ====
// constants and types shared by the boundary-scan test port
package boundary_scan_pkg;

   localparam int            IR_W          = 3;
   localparam int            ID_W          = 32;
   localparam int            BSR_LEN_DEF   = 64;
   localparam int            QBUS_CELL     = 47;
   localparam logic [2:0]    IR_CAPTURE    = 3'h1;
   localparam logic [2:0]    TMS_RESET_CNT = 3'h5;

   localparam logic [2:0]    OP_EXTEST_DEF   = 3'h0;
   localparam logic [2:0]    OP_IDCODE_DEF   = 3'h1;
   localparam logic [2:0]    OP_SAMPLE_Z_DEF = 3'h2;
   localparam logic [2:0]    OP_PRELOAD_DEF  = 3'h4;
   localparam logic [2:0]    OP_BYPASS_DEF   = 3'h7;

   // arbitrary identity value
   localparam logic [31:0]   IDCODE_DEF    = 32'h0000_0001;

   typedef enum logic [15:0] {
      ST_TLR    = 16'h0001,
      ST_RTI    = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR  = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PAU_DR = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR  = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PAU_IR = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UPD_IR = 16'h8000
   } tap_state_t;

endpackage

// ==== rtl/memory_boundary_scan_tap.sv ====
// boundary-scan test access port of the dual-port memory
// Overview of operation
// - sample all test inputs on clock rise
// - serial output changes on falling edge only
// - mode-select pin pulled up internally
// - serial data pin pulled up internally
// - instruction chooses the scan register
// - serial input enters register MSB
// - serial output taken from register LSB
// - output driven only in shift states
// - five mode-select highs force controller reset
// - controller reset leaves memory undisturbed
// - power-up reset, serial output floats
// - exactly one scan register in path
// - three-bit instruction register, serially loaded
// - reset loads identification instruction
// - capture-IR loads 01 into low bits
// - bypass is one flip-flop stage
// - bypass flip-flop cleared under BYPASS
// - boundary register captures ring, then shifts
// - ring capture under EXTEST, PRELOAD, float-sample
// - one boundary cell per package bump
// - identification capture loads 32-bit code
// - identification code is hardwired, shifted out
// - float-sample floats output bus until another instruction is loaded
// - BYPASS puts bypass flop in path
// - EXTEST drives preloaded values onto pins
// - cell 47 gates bus under EXTEST, preset high
`timescale 1ns/1ps
`default_nettype none

module memory_boundary_scan_tap #(
   parameter int           BSR_LEN     = boundary_scan_pkg::BSR_LEN_DEF,
   parameter logic [2:0]   OP_EXTEST   = boundary_scan_pkg::OP_EXTEST_DEF,
   parameter logic [2:0]   OP_IDCODE   = boundary_scan_pkg::OP_IDCODE_DEF,
   parameter logic [2:0]   OP_SAMPLE_Z = boundary_scan_pkg::OP_SAMPLE_Z_DEF,
   parameter logic [2:0]   OP_PRELOAD  = boundary_scan_pkg::OP_PRELOAD_DEF,
   parameter logic [2:0]   OP_BYPASS   = boundary_scan_pkg::OP_BYPASS_DEF,
   parameter logic [31:0]  IDCODE      = boundary_scan_pkg::IDCODE_DEF
) (
   input  wire logic               CLK_I,
   input  wire logic               RESET_I,
   input  wire logic               TCK_I,
   input  wire logic               TMS_I,
   input  wire logic               TDI_I,
   output logic                    TDO_O,
   output logic                    TDO_OE_O,
   input  wire logic [BSR_LEN-1:0] RING_I,
   output logic      [BSR_LEN-1:0] RING_O,
   output logic                    EXTEST_O,
   output logic                    QBUS_EN_O
);
   import boundary_scan_pkg::*;

   typedef struct packed {
      tap_state_t          st;
      logic [IR_W-1:0]     ir_sh;
      logic [IR_W-1:0]     ir;
      logic                byp;
      logic [ID_W-1:0]     id_sh;
      logic [BSR_LEN-1:0]  bsr_sh;
      logic [BSR_LEN-1:0]  bsr_pre;
      logic [BSR_LEN-1:0]  ring_m;
      logic [BSR_LEN-1:0]  ring_s;
      logic                pend;
      logic                req;
      logic                ack_m;
      logic                ack_s;
      logic [BSR_LEN-1:0]  xw_drv;
      logic                xw_ext;
      logic                xw_qen;
   } tck_st_t;

   typedef struct packed {
      logic tdo;
      logic oe;
   } out_st_t;

   typedef struct packed {
      logic                req_m;
      logic                req_s;
      logic                ack;
      logic [BSR_LEN-1:0]  drv;
      logic                ext;
      logic                qen;
   } sys_st_t;

   tck_st_t tck_q;
   tck_st_t tck_d;
   out_st_t out_q;
   out_st_t out_d;
   sys_st_t sys_q;
   sys_st_t sys_d;

   logic    sel_bsr;
   logic    sel_id;
   logic    sel_byp;
   logic    cap_ring;
   logic    upd_ev;
   logic    tdo_src;
   logic    shifting;
   logic    cur_ext;
   logic    cur_qen;

   // standard controller sequence
   function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
      tap_state_t n;
      n = ST_TLR;
      case (s)
         ST_TLR:    n = tms ? ST_TLR    : ST_RTI;
         ST_RTI:    n = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  n = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: n = tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: n = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: n = tms ? ST_TLR    : ST_CAP_IR;
         ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  n = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: n = tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: n = tms ? ST_SEL_DR : ST_RTI;
         default:   n = ST_TLR;
      endcase
      return n;
   endfunction

   // register selection by current instruction
   always_comb begin
      sel_bsr  = (tck_q.ir == OP_EXTEST) || (tck_q.ir == OP_PRELOAD)
                 || (tck_q.ir == OP_SAMPLE_Z);
      sel_id   = (tck_q.ir == OP_IDCODE) && !sel_bsr;
      sel_byp  = !sel_bsr && !sel_id;
      cap_ring = sel_bsr;
      shifting = (tck_q.st == ST_SH_IR) || (tck_q.st == ST_SH_DR);
      cur_ext  = (tck_q.ir == OP_EXTEST);
      cur_qen  = cur_ext ? tck_q.bsr_pre[QBUS_CELL]
                         : (tck_q.ir != OP_SAMPLE_Z);
   end

   // serial output source, low end of the chosen register
   always_comb begin
      if (tck_q.st == ST_SH_IR) begin
         tdo_src = tck_q.ir_sh[0];
      end else if (sel_id) begin
         tdo_src = tck_q.id_sh[0];
      end else if (sel_bsr) begin
         tdo_src = tck_q.bsr_sh[0];
      end else begin
         tdo_src = tck_q.byp;
      end
   end

   // link-side controller, sampled on test clock rise
   // unconnected mode-select and data pins resolve high at the pad
   always_comb begin
      tck_d        = tck_q;
      upd_ev       = 1'b0;
      tck_d.ring_m = RING_I;
      tck_d.ring_s = tck_q.ring_m;
      tck_d.ack_m  = sys_q.ack;
      tck_d.ack_s  = tck_q.ack_m;
      tck_d.st     = tap_next(tck_q.st, TMS_I);
      case (tck_q.st)
         ST_TLR: begin
            // only test state is touched, memory keeps running
            if ((tck_q.ir != OP_IDCODE) || !tck_q.bsr_pre[QBUS_CELL]) begin
               upd_ev = 1'b1;
            end
            tck_d.ir                 = OP_IDCODE;
            tck_d.bsr_pre[QBUS_CELL] = 1'b1;
         end
         ST_CAP_IR: begin
            tck_d.ir_sh = IR_CAPTURE;
         end
         ST_SH_IR: begin
            tck_d.ir_sh = {TDI_I, tck_q.ir_sh[IR_W-1:1]};
         end
         ST_UPD_IR: begin
            tck_d.ir = tck_q.ir_sh;
            upd_ev   = 1'b1;
         end
         ST_CAP_DR: begin
            if (sel_byp) begin
               tck_d.byp = 1'b0;
            end else if (sel_id) begin
               tck_d.id_sh = IDCODE;
            end else if (cap_ring) begin
               tck_d.bsr_sh = tck_q.ring_s;
            end
         end
         ST_SH_DR: begin
            if (sel_byp) begin
               tck_d.byp = TDI_I;
            end else if (sel_id) begin
               tck_d.id_sh = {TDI_I, tck_q.id_sh[ID_W-1:1]};
            end else begin
               tck_d.bsr_sh = {TDI_I, tck_q.bsr_sh[BSR_LEN-1:1]};
            end
         end
         ST_UPD_DR: begin
            if ((tck_q.ir == OP_EXTEST) || (tck_q.ir == OP_PRELOAD)) begin
               tck_d.bsr_pre = tck_q.bsr_sh;
               upd_ev        = 1'b1;
            end
         end
         default: begin
         end
      endcase
      // hand the live drive word to the memory clock domain
      if (tck_q.pend && (tck_q.req == tck_q.ack_s)) begin
         tck_d.xw_drv = tck_q.bsr_pre;
         tck_d.xw_ext = cur_ext;
         tck_d.xw_qen = cur_qen;
         tck_d.req    = ~tck_q.req;
         tck_d.pend   = 1'b0;
      end
      if (upd_ev) begin
         tck_d.pend = 1'b1;
      end
   end

   always_ff @(posedge TCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         tck_q         <= '0;
         tck_q.st      <= ST_TLR;
         tck_q.ir      <= OP_IDCODE;
         tck_q.xw_qen  <= 1'b1;
         tck_q.bsr_pre <= BSR_LEN'(1) << QBUS_CELL;
      end else begin
         tck_q <= tck_d;
      end
   end

   // serial output stage on the falling edge
   always_comb begin
      out_d     = out_q;
      out_d.tdo = tdo_src;
      out_d.oe  = shifting;
   end

   always_ff @(negedge TCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         out_q <= '0;
      end else begin
         out_q <= out_d;
      end
   end

   assign TDO_O    = out_q.tdo;
   assign TDO_OE_O = out_q.oe;

   // memory-clock side of the drive word handshake
   always_comb begin
      sys_d       = sys_q;
      sys_d.req_m = tck_q.req;
      sys_d.req_s = sys_q.req_m;
      if (sys_q.req_s != sys_q.ack) begin
         sys_d.drv = tck_q.xw_drv;
         sys_d.ext = tck_q.xw_ext;
         sys_d.qen = tck_q.xw_qen;
         sys_d.ack = sys_q.req_s;
      end
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         sys_q     <= '0;
         sys_q.qen <= 1'b1;
      end else begin
         sys_q <= sys_d;
      end
   end

   assign RING_O    = sys_q.drv;
   assign EXTEST_O  = sys_q.ext;
   assign QBUS_EN_O = sys_q.qen;

   // run length of mode-select high, for checking only
   logic [2:0] tms_run_q;

   always_ff @(posedge TCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         tms_run_q <= 3'h0;
      end else if (!TMS_I) begin
         tms_run_q <= 3'h0;
      end else if (tms_run_q != TMS_RESET_CNT) begin
         tms_run_q <= tms_run_q + 3'h1;
      end
   end

   AST_TMS_FIVE_RESET: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tms_run_q == TMS_RESET_CNT) |-> (tck_q.st == ST_TLR))
      else $error("five mode-select highs did not reach reset state");

   AST_TLR_LOADS_IDCODE: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.st == ST_TLR) |=> (tck_q.ir == OP_IDCODE))
      else $error("reset state did not load identification instruction");

   AST_CAPIR_PATTERN: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.st == ST_CAP_IR) |=> (tck_q.ir_sh[1:0] == IR_CAPTURE[1:0]))
      else $error("capture-IR pattern wrong");

   AST_IR_SHIFT_MSB: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.st == ST_SH_IR) |=> (tck_q.ir_sh[IR_W-1] == $past(TDI_I)))
      else $error("serial input did not enter instruction MSB");

   AST_BYPASS_CLEAR: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.st == ST_CAP_DR && sel_byp) |=> !tck_q.byp)
      else $error("bypass flop not cleared on capture");

   AST_ID_CAPTURE: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.st == ST_CAP_DR && sel_id) |=> (tck_q.id_sh == IDCODE))
      else $error("identification code not captured");

   AST_BSR_CAPTURE: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.st == ST_CAP_DR && sel_bsr) |=> (tck_q.bsr_sh == $past(tck_q.ring_s)))
      else $error("boundary register did not capture the ring");

   AST_TDO_ENABLE: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      TDO_OE_O == ((tck_q.st == ST_SH_IR) || (tck_q.st == ST_SH_DR)))
      else $error("serial output enabled outside shift states");

   AST_TDO_LSB: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      TDO_OE_O |-> (TDO_O == tdo_src))
      else $error("serial output not the selected register LSB");

   AST_ONE_SELECTED: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      $onehot({sel_byp, sel_id, sel_bsr}))
      else $error("scan register selection not unique");

   AST_SAMPLEZ_FLOAT: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.ir == OP_SAMPLE_Z && !tck_q.pend && tck_q.req == tck_q.ack_s
       && $past(tck_q.ir) == OP_SAMPLE_Z) |-> !tck_q.xw_qen)
      else $error("float-sample did not float the output bus");

   AST_QBUS_PRESET: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.st == ST_TLR) |=> tck_q.bsr_pre[QBUS_CELL])
      else $error("bus enable cell not preset in reset state");

   AST_SYS_HANDOFF: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      (sys_q.req_s != sys_q.ack) |=> (EXTEST_O == $past(tck_q.xw_ext)))
      else $error("drive word not taken over by memory clock domain");

   AST_BYPASS_DELAY: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.st == ST_SH_DR && sel_byp) |=> (TDO_O == $past(TDI_I)))
      else $error("bypass path not one stage long");

   AST_TDO_IR_LSB: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.st == ST_SH_IR) |-> (TDO_O == tck_q.ir_sh[0]))
      else $error("serial output not the instruction LSB");

   AST_UNSELECTED_HOLD: assert property (
      @(posedge TCK_I) disable iff (RESET_I)
      (tck_q.st == ST_SH_DR) |=> ($past(sel_byp) || $stable(tck_q.byp))
      && ($past(sel_id) || $stable(tck_q.id_sh))
      && ($past(sel_bsr) || $stable(tck_q.bsr_sh)))
      else $error("an unselected scan register shifted");

endmodule

`default_nettype wire

// ==== dv/jtag_controller_model.sv ====
// board-level test controller model that drives the scan port
`timescale 1ns/1ps
`default_nettype none

module jtag_controller_model (
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   input  wire logic tdo_i,
   input  wire logic tdo_oe_i
);
   logic last_q;
   logic oe_seen;

   initial begin
      tck_o   = 1'b0;
      tms_o   = 1'b1; // released pin reads high
      tdi_o   = 1'b1; // released pin reads high
      last_q  = 1'b0;
      oe_seen = 1'b0;
   end

   // one test-clock period, serial output taken at the rise
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      tms_o = tms;
      tdi_o = tdi;
      #7.5;
      tck_o   = 1'b1;
      oe_seen = tdo_oe_i;
      tdo     = tdo_oe_i ? tdo_i : ~last_q;
      last_q  = tdo;
      #7.5;
      tck_o = 1'b0;
   endtask

   // five high mode-select rises force the controller reset
   task automatic reset5();
      logic b;
      repeat (5) tick(1'b1, 1'b1, b);
   endtask

   // full scan from idle or reset, lsb first, back to idle
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout, output logic oe_ok);
      logic b;
      dout  = '0;
      oe_ok = 1'b1;
      tick(1'b0, 1'b1, b);
      tick(1'b1, 1'b1, b);
      if (ir) tick(1'b1, 1'b1, b);
      tick(1'b0, 1'b1, b);
      tick(1'b0, 1'b1, b);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], b);
         dout[i] = b;
         oe_ok   = oe_ok & oe_seen;
      end
      tick(1'b1, 1'b1, b);
      repeat (3) tick(1'b0, 1'b1, b);
      tms_o = 1'b1;
      tdi_o = 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== dv/memory_boundary_scan_tap_test.sv ====
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none

module memory_boundary_scan_tap_test;
   import boundary_scan_pkg::*;
   typedef struct packed {
      logic [2:0]  op;
      logic [6:0]  n;
      logic [63:0] din;
      logic [63:0] exp;
      logic        ext;
      logic        qb;
   } row_t;
   localparam logic [63:0] RING_A = 64'hA5C3_0F1E_7788_1234;
   localparam logic [63:0] D1     = 64'h0000_8000_0000_00FF;
   localparam logic [63:0] D0     = 64'h0000_0000_0000_00FF;
   localparam logic [63:0] ID64   = {32'h0, IDCODE_DEF};
   localparam row_t ROWS [10] = '{
      '{OP_IDCODE_DEF, 7'd32, D0, ID64, 1'b0, 1'b1},
      '{OP_BYPASS_DEF, 7'd4, 64'hB, 64'h6, 1'b0, 1'b1},
      '{3'h3, 7'd4, 64'hB, 64'h6, 1'b0, 1'b1},
      '{3'h5, 7'd4, 64'hB, 64'h6, 1'b0, 1'b1},
      '{3'h6, 7'd4, 64'hB, 64'h6, 1'b0, 1'b1},
      '{OP_PRELOAD_DEF, 7'd64, D1, RING_A, 1'b0, 1'b1},
      '{OP_EXTEST_DEF, 7'd64, D1, RING_A, 1'b1, 1'b1},
      '{OP_EXTEST_DEF, 7'd64, D0, RING_A, 1'b1, 1'b0},
      '{OP_SAMPLE_Z_DEF, 7'd64, D0, RING_A, 1'b0, 1'b0},
      '{OP_IDCODE_DEF, 7'd32, D0, ID64, 1'b0, 1'b1}
   };

   logic                   clk;
   logic                   rst;
   wire logic              tck;
   wire logic              tms;
   wire logic              tdi;
   wire logic              tdo;
   wire logic              tdo_oe;
   logic [BSR_LEN_DEF-1:0] ring_in;
   wire logic [BSR_LEN_DEF-1:0] ring_out;
   wire logic              extest;
   wire logic              qbus_en;
   int                     failures;
   int                     tests_run;

   memory_boundary_scan_tap i_dut (
      .CLK_I(clk), .RESET_I(rst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
      .TDO_O(tdo), .TDO_OE_O(tdo_oe), .RING_I(ring_in), .RING_O(ring_out),
      .EXTEST_O(extest), .QBUS_EN_O(qbus_en)
   );

   jtag_controller_model u_ctl (
      .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk_vec(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // instruction load, then one data scan
   task automatic op_scan(input logic [2:0] op, input int n, input logic [63:0] din,
                          output logic [63:0] dout);
      logic [63:0] iro;
      logic        ok;
      @(negedge clk);
      u_ctl.scan(1'b1, 3, {61'h0, op}, iro, ok);
      chk_vec("ir capture", 64'h1, iro);
      chk_bit("ir shift drive", 1'b1, ok);
      u_ctl.scan(1'b0, n, din, dout, ok);
      chk_bit("dr shift drive", 1'b1, ok);
      chk_bit("idle drive", 1'b0, tdo_oe);
      repeat (8) @(negedge clk);
   endtask

   initial begin
      #200_000;
      failures++;
      report_and_stop();
   end

   initial begin
      logic [63:0] got;
      logic [63:0] mask;
      logic        b;
      logic        ok;
      failures  = 0;
      tests_run = 0;
      rst       = 1'b1;
      ring_in   = RING_A;
      repeat (6) @(negedge clk);
      u_ctl.tick(1'b1, 1'b1, b);
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      chk_bit("power-up drive", 1'b0, tdo_oe);
      chk_bit("power-up bus enable", 1'b1, qbus_en);
      chk_bit("power-up extest", 1'b0, extest);
      for (int r = 0; r < 10; r++) begin
         op_scan(ROWS[r].op, int'(ROWS[r].n), ROWS[r].din, got);
         mask = (ROWS[r].n == 7'd64) ? '1 : ((64'h1 << ROWS[r].n) - 64'h1);
         chk_vec("scan out", ROWS[r].exp & mask, got & mask);
         chk_bit("extest", ROWS[r].ext, extest);
         chk_bit("bus enable", ROWS[r].qb, qbus_en);
         if (ROWS[r].ext) chk_vec("ring drive", ROWS[r].din, ring_out);
         $display("test %0d done", r);
      end
      // mode-select reset from bypass
      op_scan(OP_BYPASS_DEF, 4, 64'hB, got);
      @(negedge clk);
      u_ctl.reset5();
      chk_bit("tms reset drive", 1'b0, tdo_oe);
      u_ctl.scan(1'b0, 32, 64'h0, got, ok);
      chk_vec("id after tms reset", ID64, got & 64'hFFFF_FFFF);
      $display("test tms reset done");
      // power-up reset in mid-run under extest
      op_scan(OP_EXTEST_DEF, 64, D0, got);
      chk_bit("extest before reset", 1'b1, extest);
      rst = 1'b1;
      u_ctl.tick(1'b1, 1'b1, b);
      repeat (2) @(negedge clk);
      chk_bit("reset extest", 1'b0, extest);
      chk_bit("reset bus enable", 1'b1, qbus_en);
      chk_vec("reset ring drive", 64'h0, ring_out);
      chk_bit("reset drive", 1'b0, tdo_oe);
      rst = 1'b0;
      @(negedge clk);
      u_ctl.scan(1'b0, 32, 64'h0, got, ok);
      chk_vec("id after reset", ID64, got & 64'hFFFF_FFFF);
      $display("test async reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
